// ==== verilog/touch_sensor_settings_regs.v ====
// Settings, compensation and threshold bank of the touch controller with its control decode
`timescale 1ns/1ns
`include "touch_settings_map.vh"

module touch_sensor_settings_regs (
    input  wire        core_clk,
    input  wire        nrst,
    input  wire [7:0]  map_addr,
    input  wire [3:0]  map_index,
    input  wire        map_wr_en,
    input  wire [7:0]  map_wr_data,
    input  wire        map_rd_en,
    output reg  [7:0]  map_rd_data_reg,
    input  wire [3:0]  chan_sel,
    output reg  [7:0]  chan_comp_reg,
    output reg  [7:0]  chan_thresh_reg,
    input  wire        retune_done,
    input  wire        reseed_done,
    input  wire        low_power_exit,
    input  wire [12:0] touch_status,
    input  wire        snap_status,
    input  wire        halt_period_active,
    output wire        auto_retune_en,
    output wire        partial_tuning,
    output wire        retune_req,
    output wire        reseed_req,
    output wire        snap_detect_en,
    output reg         snap_event_reg,
    output reg         reset_flag_reg,
    output wire        soft_reset_pulse,
    output wire        turbo_mode,
    output wire        conversions_en,
    output wire        prox_projected,
    output wire        low_power_req,
    output wire        xfer_1mhz,
    output wire        tune_band_quarter,
    output wire        cs_large,
    output wire [1:0]  bias_sel,
    output wire        watchdog_timer_off,
    output wire        baseline_freeze,
    output wire        count_filter_bypass,
    output wire        comm_timeout_en,
    output wire        event_mode,
    output reg         baseline_halt_reg,
    output reg         touch_reject_reg,
    output wire        prox_all_receivers,
    output wire        relative_coords,
    output wire        unfiltered_xy,
    output wire [1:0]  beta_sel,
    output wire [7:0]  settings4_out,
    output wire [7:0]  settings5_out
);
    reg  [7:0] comp_mem [0:12];
    reg  [7:0] thresh_mem [0:12];
    reg  [7:0] set0_reg;
    reg  [7:0] set1_reg;
    reg  [7:0] set2_reg;
    reg  [7:0] set3_reg;
    reg  [7:0] set4_reg;
    reg  [7:0] set5_reg;
    reg        reset_flag_next;
    reg  [7:0] rd_next;
    integer    i;

    wire       retune_flag;
    wire       reseed_flag;
    wire       ack_flag;
    wire       sleep_flag;
    wire       soft_flag;
    wire [7:0] set0_view;
    wire [7:0] set1_view;
    wire [7:0] set2_view;
    wire       wr_set0;
    wire       wr_set1;
    wire       wr_set2;

    function hit;
        input [7:0] addr;
        input [3:0] idx;
        input [7:0] want_addr;
        input [3:0] want_idx;
        begin
            hit = (addr == want_addr) && (idx == want_idx);
        end
    endfunction

    function [3:0] count_touched;
        input [12:0] mask;
        integer k;
        begin
            count_touched = 4'h0;
            for (k = 0; k < `CHANNEL_COUNT; k = k + 1) begin
                count_touched = count_touched + {3'h0, mask[k]};
            end
        end
    endfunction

    assign wr_set0 = map_wr_en && hit(map_addr, map_index, `SETTINGS_OFFSET, `SET0_INDEX);
    assign wr_set1 = map_wr_en && hit(map_addr, map_index, `SETTINGS_OFFSET, `SET1_INDEX);
    assign wr_set2 = map_wr_en && hit(map_addr, map_index, `SETTINGS_OFFSET, `SET2_INDEX);

    // Retune request holds until the tuning pass reports done or a software reset clears it
    action_flag u_retune (
        .core_clk (core_clk),
        .nrst     (nrst),
        .set      (wr_set0 && map_wr_data[`S0_RETUNE_BIT]),
        .clear    (retune_done || soft_flag),
        .flag_reg (retune_flag)
    );

    action_flag u_reseed (
        .core_clk (core_clk),
        .nrst     (nrst),
        .set      (wr_set0 && map_wr_data[`S0_RESEED_BIT]),
        .clear    (reseed_done || soft_flag),
        .flag_reg (reseed_flag)
    );

    // Acknowledge lives one cycle: it clears the reset flag and itself on the same edge
    action_flag u_ack_reset (
        .core_clk (core_clk),
        .nrst     (nrst),
        .set      (wr_set1 && map_wr_data[`S1_ACK_RESET_BIT]),
        .clear    (ack_flag),
        .flag_reg (ack_flag)
    );

    action_flag u_force_sleep (
        .core_clk (core_clk),
        .nrst     (nrst),
        .set      (wr_set1 && map_wr_data[`S1_FORCE_SLEEP_BIT]),
        .clear    (low_power_exit || soft_flag),
        .flag_reg (sleep_flag)
    );

    action_flag u_soft_reset (
        .core_clk (core_clk),
        .nrst     (nrst),
        .set      (wr_set2 && map_wr_data[`S2_SOFT_RESET_BIT]),
        .clear    (soft_flag),
        .flag_reg (soft_flag)
    );

    // Action bits read back live, so they show zero once the work is done
    assign set0_view = {set0_reg[7:5], retune_flag, reseed_flag, set0_reg[2:0]};
    assign set1_view = {ack_flag, set1_reg[6:2], sleep_flag, set1_reg[0]};
    assign set2_view = {soft_flag, set2_reg[6:0]};

    // Storage writes; a software reset reloads defaults into every settings, compensation and threshold byte
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            set0_reg <= `SET0_RESET;
            set1_reg <= `SET1_RESET;
            set2_reg <= `SET2_RESET;
            set3_reg <= `SET3_RESET;
            set4_reg <= `SET4_RESET;
            set5_reg <= `SET5_RESET;
            for (i = 0; i < `CHANNEL_COUNT; i = i + 1) begin
                comp_mem[i] <= `COMP_RESET;
                thresh_mem[i] <= `TOUCH_THRESH_RESET;
            end
            thresh_mem[0] <= `PROX_THRESH_RESET;
        end else if (soft_flag) begin
            set0_reg <= `SET0_RESET;
            set1_reg <= `SET1_RESET;
            set2_reg <= `SET2_RESET;
            set3_reg <= `SET3_RESET;
            set4_reg <= `SET4_RESET;
            set5_reg <= `SET5_RESET;
            for (i = 0; i < `CHANNEL_COUNT; i = i + 1) begin
                comp_mem[i] <= `COMP_RESET;
                thresh_mem[i] <= `TOUCH_THRESH_RESET;
            end
            thresh_mem[0] <= `PROX_THRESH_RESET;
        end else if (map_wr_en) begin
            if (wr_set0) begin
                set0_reg <= map_wr_data;
            end
            if (wr_set1) begin
                set1_reg <= map_wr_data;
            end
            if (wr_set2) begin
                set2_reg <= map_wr_data;
            end
            if (hit(map_addr, map_index, `SETTINGS_OFFSET, `SET3_INDEX)) begin
                set3_reg <= map_wr_data;
            end
            if (hit(map_addr, map_index, `SETTINGS_OFFSET, `SET4_INDEX)) begin
                set4_reg <= map_wr_data;
            end
            if (hit(map_addr, map_index, `SETTINGS_OFFSET, `SET5_INDEX)) begin
                set5_reg <= map_wr_data;
            end
            if ((map_addr == `COMP_OFFSET) && (map_index <= `LAST_CHANNEL)) begin
                comp_mem[map_index] <= map_wr_data;
            end
            if ((map_addr == `THRESH_OFFSET) && (map_index <= `LAST_CHANNEL)) begin
                thresh_mem[map_index] <= map_wr_data;
            end
        end
    end

    // Reset indication: raised by any reset, dropped by acknowledge; a new reset wins
    always @* begin
        reset_flag_next = reset_flag_reg;
        if (ack_flag) begin
            reset_flag_next = 1'b0;
        end
        if (soft_flag) begin
            reset_flag_next = 1'b1;
        end
    end

    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            reset_flag_reg <= 1'b1;
        end else begin
            reset_flag_reg <= reset_flag_next;
        end
    end

    // Read path; unmapped bytes and the unused settings slot answer zero
    always @* begin
        rd_next = 8'h00;
        case (map_addr)
            `COMP_OFFSET: begin
                if (map_index <= `LAST_CHANNEL) begin
                    rd_next = comp_mem[map_index];
                end
            end
            `SETTINGS_OFFSET: begin
                case (map_index)
                    `SET0_INDEX: rd_next = set0_view;
                    `SET1_INDEX: rd_next = set1_view;
                    `SET2_INDEX: rd_next = set2_view;
                    `SET3_INDEX: rd_next = set3_reg;
                    `SET4_INDEX: rd_next = set4_reg;
                    `SET5_INDEX: rd_next = set5_reg;
                    default:     rd_next = 8'h00;
                endcase
            end
            `THRESH_OFFSET: begin
                if (map_index <= `LAST_CHANNEL) begin
                    rd_next = thresh_mem[map_index];
                end
            end
            default: rd_next = 8'h00;
        endcase
    end

    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            map_rd_data_reg <= 8'h00;
            chan_comp_reg <= 8'h00;
            chan_thresh_reg <= 8'h00;
        end else begin
            if (map_rd_en) begin
                map_rd_data_reg <= rd_next;
            end
            // Out-of-range channel selects give zero rather than aliasing
            if (chan_sel <= `LAST_CHANNEL) begin
                chan_comp_reg <= comp_mem[chan_sel];
                chan_thresh_reg <= thresh_mem[chan_sel];
            end else begin
                chan_comp_reg <= 8'h00;
                chan_thresh_reg <= 8'h00;
            end
        end
    end

    // Tuning controls; force-halt blocks auto-retune and retune requests, but not reseed requests
    assign auto_retune_en = !set0_reg[`S0_TUNE_OFF_BIT] && !set2_reg[`S2_FORCE_HALT_BIT];
    assign partial_tuning = set0_reg[`S0_TUNE_PART_BIT];
    assign retune_req = retune_flag && !set2_reg[`S2_FORCE_HALT_BIT];
    assign reseed_req = reseed_flag;
    assign snap_detect_en = set0_reg[`S0_SNAP_EN_BIT];
    assign soft_reset_pulse = soft_flag;
    assign cs_large = set0_reg[`S0_CS_SIZE_BIT];
    assign bias_sel = set0_reg[`S0_BIAS_HI:`S0_BIAS_LO];

    assign turbo_mode = set1_reg[`S1_TURBO_BIT];
    assign conversions_en = !set1_reg[`S1_HALT_CHARGE_BIT];
    assign prox_projected = set1_reg[`S1_PROX_PROJ_BIT];
    assign low_power_req = sleep_flag;
    assign xfer_1mhz = set1_reg[`S1_XFER_BIT];
    assign tune_band_quarter = set1_reg[`S1_TUNE_BAND_BIT];

    assign watchdog_timer_off = set2_reg[`S2_WDOG_OFF_BIT];
    assign baseline_freeze = set2_reg[`S2_FORCE_HALT_BIT];
    assign count_filter_bypass = set2_reg[`S2_FILTER_OFF_BIT];
    assign comm_timeout_en = !set2_reg[`S2_TIMEOUT_OFF_BIT];
    assign event_mode = set2_reg[`S2_EVENT_MODE_BIT];

    assign prox_all_receivers = set3_reg[`S3_RX_ALL_BIT];
    assign relative_coords = set3_reg[`S3_RELATIVE_BIT];
    assign unfiltered_xy = set3_reg[`S3_UNFILTERED_BIT];
    assign beta_sel = set3_reg[`S3_BETA_HI:`S3_BETA_LO];
    assign settings4_out = set4_reg;
    assign settings5_out = set5_reg;

    // Snap events, baseline halting and touch rejection are registered decisions
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            snap_event_reg <= 1'b0;
            baseline_halt_reg <= 1'b0;
            touch_reject_reg <= 1'b0;
        end else begin
            snap_event_reg <= snap_status && set0_reg[`S0_SNAP_EN_BIT];
            if (set2_reg[`S2_FORCE_HALT_BIT]) begin
                baseline_halt_reg <= 1'b1;
            end else begin
                case (set2_reg[`S2_HALT_HI:`S2_HALT_LO])
                    `HALT_NEVER:  baseline_halt_reg <= 1'b0;
                    `HALT_ALWAYS: baseline_halt_reg <= !(snap_status &&
                                                         set0_reg[`S0_SNAP_EN_BIT]);
                    default:      baseline_halt_reg <= halt_period_active;
                endcase
            end
            if (!set3_reg[`S3_REJECT_EN_BIT]) begin
                touch_reject_reg <= 1'b0;
            end else if (set3_reg[`S3_BLOCK_SEL_BIT]) begin
                touch_reject_reg <= count_touched(touch_status) >= `REJECT_COUNT_HIGH;
            end else begin
                touch_reject_reg <= count_touched(touch_status) >= `REJECT_COUNT_LOW;
            end
        end
    end
endmodule

// ==== verilog/touch_settings_map.vh ====
// Memory-map offsets, byte indices, field positions and reset values of the settings bank
`ifndef TOUCH_SETTINGS_MAP_VH
`define TOUCH_SETTINGS_MAP_VH

`define COMP_OFFSET          8'h07
`define SETTINGS_OFFSET      8'h08
`define THRESH_OFFSET        8'h09

`define CHANNEL_COUNT        13
`define LAST_CHANNEL         4'hc

`define SET0_INDEX           4'h0
`define SET1_INDEX           4'h1
`define SET2_INDEX           4'h2
`define SET3_INDEX           4'h3
`define SET4_INDEX           4'h5
`define SET5_INDEX           4'h6

`define COMP_RESET           8'h00
`define SET0_RESET           8'h06
`define SET1_RESET           8'h00
`define SET2_RESET           8'h00
`define SET3_RESET           8'h06
`define SET4_RESET           8'h07
`define SET5_RESET           8'h7f
`define PROX_THRESH_RESET    8'h04
`define TOUCH_THRESH_RESET   8'h10

`define S0_TUNE_OFF_BIT      7
`define S0_TUNE_PART_BIT     6
`define S0_SNAP_EN_BIT       5
`define S0_RETUNE_BIT        4
`define S0_RESEED_BIT        3
`define S0_CS_SIZE_BIT       2
`define S0_BIAS_HI           1
`define S0_BIAS_LO           0

`define S1_ACK_RESET_BIT     7
`define S1_XFER_BIT          6
`define S1_TURBO_BIT         5
`define S1_HALT_CHARGE_BIT   4
`define S1_PROX_PROJ_BIT     2
`define S1_FORCE_SLEEP_BIT   1
`define S1_TUNE_BAND_BIT     0

`define S2_SOFT_RESET_BIT    7
`define S2_WDOG_OFF_BIT      6
`define S2_FORCE_HALT_BIT    5
`define S2_FILTER_OFF_BIT    4
`define S2_TIMEOUT_OFF_BIT   3
`define S2_EVENT_MODE_BIT    2
`define S2_HALT_HI           1
`define S2_HALT_LO           0

`define S3_BLOCK_SEL_BIT     7
`define S3_BETA_HI           5
`define S3_BETA_LO           4
`define S3_REJECT_EN_BIT     3
`define S3_RX_ALL_BIT        2
`define S3_RELATIVE_BIT      1
`define S3_UNFILTERED_BIT    0

`define HALT_NEVER           2'h2
`define HALT_ALWAYS          2'h3

`define REJECT_COUNT_LOW     4'h5
`define REJECT_COUNT_HIGH    4'h7

`endif

// ==== verilog/action_flag.v ====
// Self-clearing action bit: host sets it, device logic clears it, a set beats a clear
`timescale 1ns/1ns
module action_flag (
    input  wire core_clk,
    input  wire nrst,
    input  wire set,
    input  wire clear,
    output reg  flag_reg
);
    reg flag_next;

    always @* begin
        flag_next = flag_reg;
        if (clear) begin
            flag_next = 1'b0;
        end
        // A write that lands with the clear must not be lost
        if (set) begin
            flag_next = 1'b1;
        end
    end

    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            flag_reg <= 1'b0;
        end else begin
            flag_reg <= flag_next;
        end
    end
endmodule

// ==== bench/core_model.sv ====
// Behavioural core answering the bank's action requests after a delay
`timescale 1ns/1ns
module core_model #(
    parameter int DELAY = 3
) (
    input  wire logic       core_clk,
    input  wire logic       nrst,
    input  wire logic       stall,
    input  wire logic [2:0] req,
    output logic      [2:0] done
);
    int cnt [3];
    // Stall freezes the count so the bench can look at a pending request
    always @(posedge core_clk or negedge nrst) begin
        for (int i = 0; i < 3; i++) begin
            if (!nrst) begin
                cnt[i] <= 0;
                done[i] <= 1'b0;
            end else begin
                done[i] <= 1'b0;
                if (!req[i] || done[i]) begin
                    cnt[i] <= 0;
                end else if (cnt[i] == DELAY) begin
                    done[i] <= 1'b1;
                end else if (!stall) begin
                    cnt[i] <= cnt[i] + 1;
                end
            end
        end
    end
endmodule

// ==== bench/touch_settings_asserts.sv ====
// Concurrent checks on the settings bank ports
`timescale 1ns/1ns
module touch_settings_checker (
    input wire        core_clk,
    input wire        nrst,
    input wire [7:0]  map_addr,
    input wire [3:0]  map_index,
    input wire        map_wr_en,
    input wire [7:0]  map_wr_data,
    input wire        map_rd_en,
    input wire [7:0]  map_rd_data_reg,
    input wire [12:0] touch_status,
    input wire        retune_done,
    input wire        low_power_exit,
    input wire        retune_req,
    input wire        low_power_req,
    input wire        snap_detect_en,
    input wire        snap_event_reg,
    input wire        reset_flag_reg,
    input wire        soft_reset_pulse,
    input wire        turbo_mode,
    input wire        conversions_en,
    input wire        comm_timeout_en,
    input wire [7:0]  settings5_out,
    input wire        baseline_freeze,
    input wire        baseline_halt_reg,
    input wire        touch_reject_reg
);
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (!nrst);
    // Writes during a soft reset cycle are dropped, so they are left out
    wire sw = map_wr_en && map_addr == 8'h08 && !soft_reset_pulse;
    wire w0 = sw && map_index == 4'h0;
    wire w1 = sw && map_index == 4'h1;
    wire w2 = sw && map_index == 4'h2;
    turbo_write_a: assert property (w1 |=> turbo_mode == $past(map_wr_data[5]))
        else $error("turbo mode differs from written bit");
    halt_charge_a: assert property (w1 |=> conversions_en == !$past(map_wr_data[4]))
        else $error("conversion enable differs from written bit");
    ack_clear_a: assert property (w1 && map_wr_data[7] ##1 !soft_reset_pulse |=> !reset_flag_reg)
        else $error("reset flag not cleared by acknowledge");
    retune_clear_a: assert property (retune_done && !soft_reset_pulse && !(w0 && map_wr_data[4])
        |=> !retune_req)
        else $error("retune request stays after completion");
    sleep_clear_a: assert property (low_power_exit && !soft_reset_pulse && !(w1 && map_wr_data[1])
        |=> !low_power_req)
        else $error("sleep request stays after low power exit");
    soft_default_a: assert property (soft_reset_pulse |=> reset_flag_reg && !turbo_mode
        && conversions_en && settings5_out == 8'h7f)
        else $error("soft reset did not restore defaults");
    timeout_write_a: assert property (w2 |=> comm_timeout_en == !$past(map_wr_data[3]))
        else $error("timeout enable differs from written bit");
    freeze_halt_a: assert property (baseline_freeze && !soft_reset_pulse |=> baseline_halt_reg)
        else $error("baseline not halted while frozen");
    reject_count_a: assert property (touch_reject_reg |-> $countones($past(touch_status)) >= 5)
        else $error("touch rejected below five touches");
    snap_off_a: assert property (!snap_detect_en |=> !snap_event_reg)
        else $error("snap event while snap detection off");
    readback_a: assert property (map_rd_en && map_addr == 8'h08 && map_index == 4'h1
        |=> map_rd_data_reg[5] == $past(turbo_mode))
        else $error("readback differs from turbo mode");
endmodule

bind touch_sensor_settings_regs touch_settings_checker chk (
    .core_clk(core_clk), .nrst(nrst), .map_addr(map_addr), .map_index(map_index),
    .map_wr_en(map_wr_en), .map_wr_data(map_wr_data), .map_rd_en(map_rd_en),
    .map_rd_data_reg(map_rd_data_reg), .touch_status(touch_status),
    .retune_done(retune_done), .low_power_exit(low_power_exit), .retune_req(retune_req),
    .low_power_req(low_power_req), .snap_detect_en(snap_detect_en),
    .snap_event_reg(snap_event_reg), .reset_flag_reg(reset_flag_reg),
    .soft_reset_pulse(soft_reset_pulse), .turbo_mode(turbo_mode),
    .conversions_en(conversions_en), .comm_timeout_en(comm_timeout_en),
    .settings5_out(settings5_out), .baseline_freeze(baseline_freeze),
    .baseline_halt_reg(baseline_halt_reg), .touch_reject_reg(touch_reject_reg)
);

// ==== bench/touch_sensor_settings_regs_tb.sv ====
// Self-checking bench for the settings bank
`timescale 1ns/1ns
module touch_sensor_settings_regs_tb;
    logic        core_clk = 1'b0;
    logic        nrst = 1'b0;
    logic [7:0]  map_addr = 8'h00;
    logic [3:0]  map_index = 4'h0;
    logic        map_wr_en = 1'b0;
    logic [7:0]  map_wr_data = 8'h00;
    logic        map_rd_en = 1'b0;
    logic [3:0]  chan_sel = 4'h0;
    logic [12:0] touch_status = 13'h0000;
    logic        snap_status = 1'b0;
    logic        halt_period_active = 1'b0;
    logic        stall = 1'b1;
    int          fails = 0;
    int          checks = 0;
    wire  [7:0]  map_rd_data_reg, chan_thresh_reg, settings5_out, settings4_out;
    wire         retune_done, reseed_done, low_power_exit, auto_retune_en, partial_tuning;
    wire         retune_req, reseed_req, snap_detect_en, snap_event_reg, reset_flag_reg;
    wire         soft_reset_pulse, turbo_mode, conversions_en, prox_projected, low_power_req;
    wire         baseline_freeze, count_filter_bypass, comm_timeout_en, event_mode;
    wire         baseline_halt_reg, touch_reject_reg, prox_all_receivers, relative_coords;
    wire         unfiltered_xy, xfer_1mhz, tune_band_quarter, cs_large, watchdog_timer_off;
    wire  [1:0]  bias_sel, beta_sel;

    always #5 core_clk = ~core_clk;

    touch_sensor_settings_regs uut (
        .core_clk(core_clk), .nrst(nrst), .map_addr(map_addr), .map_index(map_index),
        .map_wr_en(map_wr_en), .map_wr_data(map_wr_data), .map_rd_en(map_rd_en),
        .map_rd_data_reg(map_rd_data_reg), .chan_sel(chan_sel), .chan_comp_reg(),
        .chan_thresh_reg(chan_thresh_reg), .retune_done(retune_done),
        .reseed_done(reseed_done), .low_power_exit(low_power_exit),
        .touch_status(touch_status), .snap_status(snap_status),
        .halt_period_active(halt_period_active), .auto_retune_en(auto_retune_en),
        .partial_tuning(partial_tuning), .retune_req(retune_req), .reseed_req(reseed_req),
        .snap_detect_en(snap_detect_en), .snap_event_reg(snap_event_reg),
        .reset_flag_reg(reset_flag_reg), .soft_reset_pulse(soft_reset_pulse),
        .turbo_mode(turbo_mode), .conversions_en(conversions_en),
        .prox_projected(prox_projected), .low_power_req(low_power_req), .xfer_1mhz(xfer_1mhz),
        .tune_band_quarter(tune_band_quarter), .cs_large(cs_large), .bias_sel(bias_sel),
        .watchdog_timer_off(watchdog_timer_off),
        .baseline_freeze(baseline_freeze), .count_filter_bypass(count_filter_bypass),
        .comm_timeout_en(comm_timeout_en), .event_mode(event_mode),
        .baseline_halt_reg(baseline_halt_reg), .touch_reject_reg(touch_reject_reg),
        .prox_all_receivers(prox_all_receivers), .relative_coords(relative_coords),
        .unfiltered_xy(unfiltered_xy), .beta_sel(beta_sel), .settings4_out(settings4_out),
        .settings5_out(settings5_out)
    );

    core_model #(.DELAY(3)) partner (
        .core_clk(core_clk), .nrst(nrst), .stall(stall),
        .req({low_power_req, reseed_req, retune_req}),
        .done({low_power_exit, reseed_done, retune_done})
    );

    task automatic ck(input string n, input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic st(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [3:0] i, input logic [7:0] d);
        @(posedge core_clk);
        map_addr <= a;
        map_index <= i;
        map_wr_data <= d;
        map_wr_en <= 1'b1;
        @(posedge core_clk);
        map_wr_en <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [3:0] i, input logic [7:0] e);
        @(posedge core_clk);
        map_addr <= a;
        map_index <= i;
        map_rd_en <= 1'b1;
        @(posedge core_clk);
        map_rd_en <= 1'b0;
        #1;
        ck("read", e, map_rd_data_reg);
    endtask

    task automatic t_reset;
        logic [7:0] dflt [7] = '{8'h06, 8'h00, 8'h00, 8'h06, 8'h00, 8'h07, 8'h7f};
        for (int i = 0; i < 7; i++) rd(8'h08, i[3:0], dflt[i]);
        rd(8'h09, 4'hc, 8'h10);
        rd(8'h09, 4'hd, 8'h00);
        @(posedge core_clk);
        chan_sel <= 4'h0;
        st(1);
        ck("thresh", 8'h04, chan_thresh_reg);
        ck("rflag", 1'b1, reset_flag_reg);
        $display("done reset");
    endtask

    task automatic t_set1;
        wr(8'h08, 4'h1, 8'h34);
        st(0);
        ck("turbo", 1'b1, turbo_mode);
        ck("conv", 1'b0, conversions_en);
        ck("proj", 1'b1, prox_projected);
        rd(8'h08, 4'h1, 8'h34);
        wr(8'h08, 4'h1, 8'h00);
        st(0);
        ck("conv", 1'b1, conversions_en);
        ck("proj", 1'b0, prox_projected);
        wr(8'h08, 4'h1, 8'h80);
        st(1);
        ck("rflag", 1'b0, reset_flag_reg);
        rd(8'h08, 4'h1, 8'h00);
        $display("done settings1");
    endtask

    task automatic t_action;
        wr(8'h08, 4'h0, 8'hfe);
        snap_status <= 1'b1;
        st(0);
        ck("auto", 1'b0, auto_retune_en);
        ck("partial", 1'b1, partial_tuning);
        ck("reqs", 2'b11, {retune_req, reseed_req});
        rd(8'h08, 4'h0, 8'hfe);
        stall <= 1'b0;
        repeat (40) if (retune_req || reseed_req) @(posedge core_clk);
        #1;
        ck("reqs", 2'b00, {retune_req, reseed_req});
        ck("snap", 1'b1, snap_event_reg);
        rd(8'h08, 4'h0, 8'he6);
        stall <= 1'b1;
        wr(8'h08, 4'h1, 8'h02);
        wr(8'h08, 4'h0, 8'h06);
        st(2);
        ck("snap", 1'b0, snap_event_reg);
        ck("sleep", 1'b1, low_power_req);
        stall <= 1'b0;
        repeat (40) if (low_power_req) @(posedge core_clk);
        rd(8'h08, 4'h1, 8'h00);
        $display("done actions");
    endtask

    task automatic t_set2;
        wr(8'h08, 4'h2, 8'h5c);
        snap_status <= 1'b0;
        st(0);
        ck("bypass", 1'b1, count_filter_bypass);
        ck("timeout", 1'b0, comm_timeout_en);
        ck("event", 1'b1, event_mode);
        stall <= 1'b1;
        wr(8'h08, 4'h2, 8'h22);
        wr(8'h08, 4'h0, 8'h16);
        st(0);
        ck("freeze", 3'b100, {baseline_freeze, auto_retune_en, retune_req});
        ck("halt", 1'b1, baseline_halt_reg);
        ck("event", 1'b0, event_mode);
        wr(8'h08, 4'h2, 8'h00);
        st(0);
        ck("retune", 1'b1, retune_req);
        stall <= 1'b0;
        repeat (40) if (retune_req) @(posedge core_clk);
        $display("done settings2");
    endtask

    task automatic t_halt;
        logic [4:0] tab [6] = '{5'b00101, 5'b01000, 5'b01101, 5'b10100, 5'b11001, 5'b11110};
        wr(8'h08, 4'h0, 8'h26);
        for (int i = 0; i < 6; i++) begin
            wr(8'h08, 4'h2, {6'h00, tab[i][4:3]});
            halt_period_active <= tab[i][2];
            snap_status <= tab[i][1];
            st(1);
            ck("bhalt", tab[i][0], baseline_halt_reg);
        end
        wr(8'h08, 4'h0, 8'h06);
        snap_status <= 1'b0;
        $display("done halt");
    endtask

    task automatic t_reject;
        logic [7:0] s [5] = '{8'h08, 8'h08, 8'h88, 8'h88, 8'h80};
        int n [5] = '{4, 5, 6, 7, 7};
        logic e [5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
        for (int i = 0; i < 5; i++) begin
            wr(8'h08, 4'h3, s[i]);
            touch_status <= (13'h0001 << n[i]) - 13'h0001;
            st(1);
            ck("reject", e[i], touch_reject_reg);
        end
        wr(8'h08, 4'h3, 8'h03);
        st(0);
        ck("coords", 3'b011, {prox_all_receivers, relative_coords, unfiltered_xy});
        $display("done reject");
    endtask

    task automatic t_soft;
        wr(8'h08, 4'h1, 8'h61);
        wr(8'h09, 4'hc, 8'h5a);
        wr(8'h08, 4'h2, 8'h80);
        st(0);
        ck("soft", 1'b1, soft_reset_pulse);
        st(1);
        ck("state", 3'b001, {soft_reset_pulse, turbo_mode, reset_flag_reg});
        ck("set01", 8'h06, {xfer_1mhz, tune_band_quarter, cs_large, bias_sel});
        ck("set23", 8'h00, {watchdog_timer_off, beta_sel});
        ck("set4", 8'h07, settings4_out);
        rd(8'h08, 4'h3, 8'h06);
        rd(8'h09, 4'hc, 8'h10);
        rd(8'h08, 4'h2, 8'h00);
        $display("done soft reset");
    endtask

    task automatic give_verdict;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge core_clk);
        fails++;
        give_verdict;
    end

    initial begin
        repeat (16) @(posedge core_clk);
        nrst <= 1'b1;
        t_reset;
        t_set1;
        t_action;
        t_set2;
        t_halt;
        t_reject;
        t_soft;
        give_verdict;
    end
endmodule
